/* design/pscl_map.vh */
// Constants of the power-management serial control logic.
// Assumes it is included by bare name from the design files and the bench.
`ifndef PSCL_MAP_VH
`define PSCL_MAP_VH

// Seven-bit target address on the serial bus.
`define PSCL_TARGET_ADDR 7'h48

// Register offsets.
`define PSCL_OFS_STATUS 8'h01
`define PSCL_OFS_CTRL 8'h02
`define PSCL_OFS_MODE 8'h03
`define PSCL_OFS_BUCK1_V 8'h04
`define PSCL_OFS_REG_V_A 8'h05
`define PSCL_OFS_REG_V_B 8'h06

// Supply enable control register fields.
`define PSCL_CTRL_HOST_RESET 7
`define PSCL_CTRL_DEEP_PD 6
`define PSCL_CTRL_BUCK1_EN 5
`define PSCL_CTRL_BUCK2_EN 4
`define PSCL_CTRL_REG1_EN 3
`define PSCL_CTRL_REG4_EN 0

// Rail status register fields.
`define PSCL_STAT_DISCHARGE 7
`define PSCL_STAT_TRANSITION 6

// Reset values.
`define PSCL_CTRL_RESET 8'h00
`define PSCL_MODE_RESET 4'h1
`define PSCL_MODE_BITS 4
`define PSCL_UNMAPPED_READ 8'h00

// Voltage codes held in each nibble of the setting fields; buck1 uses the low nibble only.
`define PSCL_V_1P0 4'h0
`define PSCL_V_1P2 4'h1
`define PSCL_V_1P3 4'h2
`define PSCL_V_1P8 4'h3
`define PSCL_V_1P9 4'h4
`define PSCL_V_2P1 4'h5
`define PSCL_V_2P8 4'h6
`define PSCL_V_3P0 4'h7

// Three-level pin encoding.
`define PSCL_LVL_LOW 2'h0
`define PSCL_LVL_HIGH 2'h1
`define PSCL_LVL_FLOAT 2'h2

// Cycles after reset release before the default-select pins are taken.
`define PSCL_LATCH_WAIT 2'h3

`endif

/* design/pscl_sync.v */
// Two-flop synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level or a signal much slower than the clock.
module pscl_sync #(
	parameter WIDTH = 1
) (
	input wire i_mclk,
	input wire i_rst_b,
	input wire [WIDTH-1:0] i_async,
	output reg [WIDTH-1:0] o_sync
);

reg [WIDTH-1:0] meta;

// Only the second stage is visible outside, so metastability stays inside.
always @(posedge i_mclk or negedge i_rst_b)
begin
	if (!i_rst_b)
	begin
		meta <= {WIDTH{1'b0}};
		o_sync <= {WIDTH{1'b0}};
	end
	else
	begin
		meta <= i_async;
		o_sync <= meta;
	end
end

endmodule

/* design/pscl_top.v */
// Digital control logic of a dual-buck, quad-regulator power manager with a serial target port.
// Assumes i_rst_b is the release from undervoltage lockout and that all pins are asynchronous.
//
// Overview of operation
// - After lockout release both open-drain host outputs are driven low.
// - Software sets each host output level through its control register bit.
// - Any buck over-temperature switches both bucks off together.
// - Bucks restart by themselves once the over-temperature indication clears.
// - Any regulator over-temperature switches all four regulators off together.
// - Regulator enable is pin XOR control bit at register 02h.
// - After lockout the default-select pins are sampled and loaded into voltage registers.
// - Software may later overwrite all latched voltage settings.
// - Regulators 1-3 default 1.2/1.8/2.8 V, or 1.0/1.2/1.0 V when both pins high.
// - Regulator4 and buck1 defaults come from a nine-entry pin lookup.
// - Device is OFF in lockout and ON, rails available, once released.
// - Serial port supports standard and fast modes up to 400 kHz.
// - Registers keep their values until the next lockout.
// - Only target address 1001000 is answered.
// - Reads of unimplemented addresses return 00h.
// - Data line is held low through each acknowledge clock high phase.
// - On master not-acknowledge the data line is released for the stop.
// - Data changes only while clock low; start and stop frame transfers.
// - Rail status register is read-only: discharge, transition, six not-good flags.
// - A not-good flag reads 1 when its rail is low or disabled.
// - Host output bit 0 drives the pin low, 1 releases it.
// - Pin and bit equal give disabled, differing give enabled.
`include "pscl_map.vh"

module pscl_top (
	input wire i_mclk,
	input wire i_rst_b,
	input wire i_scl,
	input wire i_sda,
	output reg o_sda_out,
	output reg o_sda_oe,
	input wire i_buck1_enable_pin,
	input wire i_buck2_enable_pin,
	input wire i_regulator1_enable_pin,
	input wire i_regulator2_enable_pin,
	input wire i_regulator3_enable_pin,
	input wire i_regulator4_enable_pin,
	input wire i_default_select_pin_a,
	input wire i_default_select_pin_a_float,
	input wire i_default_select_pin_b,
	input wire i_default_select_pin_b_float,
	input wire [1:0] i_buck_overtemp,
	input wire [3:0] i_regulator_overtemp,
	input wire [5:0] i_rail_in_range,
	input wire i_discharge_above,
	input wire i_voltage_transition_active,
	output reg o_host_reset_out,
	output reg o_host_reset_oe,
	output reg o_deep_power_down_output_out,
	output reg o_deep_power_down_output_oe,
	output reg o_device_on,
	output reg o_buck1_enable,
	output reg o_buck2_enable,
	output reg [3:0] o_regulator_enable,
	output reg [3:0] o_conv_mode,
	output reg [7:0] o_buck1_voltage_setting,
	output reg [7:0] o_regulator_voltage_setting_a,
	output reg [7:0] o_regulator_voltage_setting_b
);

////////////////////////////////////////////////////////////////////////////////

localparam ST_IDLE = 3'd0;
localparam ST_RECV = 3'd1;
localparam ST_ACK = 3'd2;
localparam ST_SEND = 3'd3;
localparam ST_MACK = 3'd4;

localparam KIND_ADDR = 2'd0;
localparam KIND_PTR = 2'd1;
localparam KIND_DATA = 2'd2;

wire [25:0] sync_out;
wire scl_s;
wire sda_s;
wire [5:0] en_pin;
wire sel_a;
wire sel_a_fl;
wire sel_b;
wire sel_b_fl;
wire [1:0] buck_ot;
wire [3:0] reg_ot;
wire [5:0] rail_ok;
wire dis_above;
wire dvm_act;

// Every pin goes through the two-flop bundle before any logic looks at it.
pscl_sync #(
	.WIDTH(26)
) u_sync (
	.i_mclk(i_mclk),
	.i_rst_b(i_rst_b),
	.i_async({i_scl, i_sda, i_buck1_enable_pin, i_buck2_enable_pin, i_regulator1_enable_pin,
		i_regulator2_enable_pin, i_regulator3_enable_pin, i_regulator4_enable_pin,
		i_default_select_pin_a, i_default_select_pin_a_float, i_default_select_pin_b,
		i_default_select_pin_b_float, i_buck_overtemp, i_regulator_overtemp, i_rail_in_range,
		i_discharge_above, i_voltage_transition_active}),
	.o_sync(sync_out)
);

assign {scl_s, sda_s, en_pin, sel_a, sel_a_fl, sel_b, sel_b_fl, buck_ot, reg_ot, rail_ok,
	dis_above, dvm_act} = sync_out;

////////////////////////////////////////////////////////////////////////////////

reg scl_d;
reg sda_d;
wire scl_rise;
wire scl_fall;
wire bus_start;
wire bus_stop;

always @(posedge i_mclk or negedge i_rst_b)
begin
	if (!i_rst_b)
	begin
		scl_d <= 1'b1;
		sda_d <= 1'b1;
	end
	else
	begin
		scl_d <= scl_s;
		sda_d <= sda_s;
	end
end

// At least four samples per bus clock phase keep pace with 400 kHz buses.
assign scl_rise = scl_s & ~scl_d;
assign scl_fall = ~scl_s & scl_d;
// Data edges with the clock high are framing, never data.
assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

////////////////////////////////////////////////////////////////////////////////

// Returns {regulator4 code, buck1 code} for the two three-level pins.
function [7:0] pscl_lookup;
	input [1:0] lvl_b;
	input [1:0] lvl_a;
	begin
		pscl_lookup = {`PSCL_V_1P3, `PSCL_V_2P1};
		case ({lvl_b, lvl_a})
			{`PSCL_LVL_LOW, `PSCL_LVL_LOW}: pscl_lookup = {`PSCL_V_1P3, `PSCL_V_2P1};
			{`PSCL_LVL_LOW, `PSCL_LVL_FLOAT}: pscl_lookup = {`PSCL_V_2P8, `PSCL_V_1P8};
			{`PSCL_LVL_LOW, `PSCL_LVL_HIGH}: pscl_lookup = {`PSCL_V_1P3, `PSCL_V_1P8};
			{`PSCL_LVL_FLOAT, `PSCL_LVL_LOW}: pscl_lookup = {`PSCL_V_2P8, `PSCL_V_2P1};
			{`PSCL_LVL_FLOAT, `PSCL_LVL_FLOAT}: pscl_lookup = {`PSCL_V_1P8, `PSCL_V_2P1};
			{`PSCL_LVL_FLOAT, `PSCL_LVL_HIGH}: pscl_lookup = {`PSCL_V_2P8, `PSCL_V_1P2};
			{`PSCL_LVL_HIGH, `PSCL_LVL_LOW}: pscl_lookup = {`PSCL_V_1P0, `PSCL_V_1P9};
			{`PSCL_LVL_HIGH, `PSCL_LVL_FLOAT}: pscl_lookup = {`PSCL_V_3P0, `PSCL_V_2P1};
			{`PSCL_LVL_HIGH, `PSCL_LVL_HIGH}: pscl_lookup = {`PSCL_V_1P0, `PSCL_V_1P2};
			default: pscl_lookup = {`PSCL_V_1P3, `PSCL_V_2P1};
		endcase
	end
endfunction

wire [1:0] lvl_a;
wire [1:0] lvl_b;
wire both_high;
wire [7:0] pin_pick;

// A float indication overrides the logic level read from the same pin.
assign lvl_a = sel_a_fl ? `PSCL_LVL_FLOAT : (sel_a ? `PSCL_LVL_HIGH : `PSCL_LVL_LOW);
assign lvl_b = sel_b_fl ? `PSCL_LVL_FLOAT : (sel_b ? `PSCL_LVL_HIGH : `PSCL_LVL_LOW);
assign both_high = (lvl_a == `PSCL_LVL_HIGH) && (lvl_b == `PSCL_LVL_HIGH);
assign pin_pick = pscl_lookup(lvl_b, lvl_a);

////////////////////////////////////////////////////////////////////////////////

reg [2:0] state;
reg [1:0] kind;
reg [3:0] bitcnt;
reg [7:0] shift;
reg [7:0] ptr;
reg rw;
reg mnack;
reg [1:0] wait_cnt;
reg [7:0] ctrl;
reg [3:0] mode;
reg [7:0] buck1_v;
reg [7:0] reg_v_a;
reg [7:0] reg_v_b;
reg [7:0] status;
reg [7:0] rd_data;
wire wr_commit;

// A data byte lands only when its acknowledge clock ends.
assign wr_commit = scl_fall && (state == ST_ACK) && (kind == KIND_DATA);

// Unlisted addresses read zero; the status register has no write path.
always @*
begin
	case (ptr)
		`PSCL_OFS_STATUS: rd_data = status;
		`PSCL_OFS_CTRL: rd_data = ctrl;
		`PSCL_OFS_MODE: rd_data = {4'h0, mode};
		`PSCL_OFS_BUCK1_V: rd_data = buck1_v;
		`PSCL_OFS_REG_V_A: rd_data = reg_v_a;
		`PSCL_OFS_REG_V_B: rd_data = reg_v_b;
		default: rd_data = `PSCL_UNMAPPED_READ;
	endcase
end

////////////////////////////////////////////////////////////////////////////////

// Serial target engine; lockout release parks it idle.
always @(posedge i_mclk or negedge i_rst_b)
begin
	if (!i_rst_b)
	begin
		state <= ST_IDLE;
		kind <= KIND_ADDR;
		bitcnt <= 4'h0;
		shift <= 8'h00;
		ptr <= 8'h00;
		rw <= 1'b0;
		mnack <= 1'b1;
		o_sda_oe <= 1'b0;
	end
	else if (bus_start)
	begin
		state <= ST_RECV;
		kind <= KIND_ADDR;
		bitcnt <= 4'h0;
		o_sda_oe <= 1'b0;
	end
	else if (bus_stop)
	begin
		state <= ST_IDLE;
		o_sda_oe <= 1'b0;
	end
	else
	begin
		case (state)
			ST_IDLE:
			begin
				o_sda_oe <= 1'b0;
			end
			ST_RECV:
			begin
				if (scl_rise && bitcnt != 4'h8)
				begin
					shift <= {shift[6:0], sda_s};
					bitcnt <= bitcnt + 4'h1;
				end
				else if (scl_fall && bitcnt == 4'h8)
				begin
					bitcnt <= 4'h0;
					if (kind != KIND_ADDR)
					begin
						o_sda_oe <= 1'b1;
						state <= ST_ACK;
					end
					else if (shift[7:1] == `PSCL_TARGET_ADDR)
					begin
						rw <= shift[0];
						o_sda_oe <= 1'b1;
						state <= ST_ACK;
					end
					else
					begin
						state <= ST_IDLE;
					end
				end
			end
			ST_ACK:
			begin
				// Low is held across the whole ninth clock high.
				if (scl_fall)
				begin
					if (kind == KIND_ADDR && rw)
					begin
						shift <= rd_data;
						o_sda_oe <= ~rd_data[7];
						bitcnt <= 4'h1;
						ptr <= ptr + 8'h01;
						state <= ST_SEND;
					end
					else
					begin
						o_sda_oe <= 1'b0;
						state <= ST_RECV;
						if (kind == KIND_ADDR)
						begin
							kind <= KIND_PTR;
						end
						else if (kind == KIND_PTR)
						begin
							ptr <= shift;
							kind <= KIND_DATA;
						end
						else
						begin
							ptr <= ptr + 8'h01;
						end
					end
				end
			end
			ST_SEND:
			begin
				// Data bits move only on the falling clock edge.
				if (scl_fall)
				begin
					if (bitcnt == 4'h8)
					begin
						o_sda_oe <= 1'b0;
						state <= ST_MACK;
					end
					else
					begin
						o_sda_oe <= ~shift[6];
						shift <= {shift[6:0], 1'b0};
						bitcnt <= bitcnt + 4'h1;
					end
				end
			end
			ST_MACK:
			begin
				if (scl_rise)
				begin
					mnack <= sda_s;
				end
				else if (scl_fall)
				begin
					if (mnack)
					begin
						o_sda_oe <= 1'b0;
						state <= ST_IDLE;
					end
					else
					begin
						shift <= rd_data;
						o_sda_oe <= ~rd_data[7];
						bitcnt <= 4'h1;
						ptr <= ptr + 8'h01;
						state <= ST_SEND;
					end
				end
			end
			default:
			begin
				state <= ST_IDLE;
				o_sda_oe <= 1'b0;
			end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////

// Registers reset only on lockout and otherwise hold.
always @(posedge i_mclk or negedge i_rst_b)
begin
	if (!i_rst_b)
	begin
		wait_cnt <= 2'h0;
		o_device_on <= 1'b0;
		ctrl <= `PSCL_CTRL_RESET;
		mode <= `PSCL_MODE_RESET;
		buck1_v <= {4'h0, `PSCL_V_2P1};
		reg_v_a <= {`PSCL_V_1P8, `PSCL_V_1P2};
		reg_v_b <= {`PSCL_V_1P3, `PSCL_V_2P8};
	end
	else if (!o_device_on)
	begin
		// The wait lets the pin levels pass the synchroniser first.
		wait_cnt <= wait_cnt + 2'h1;
		if (wait_cnt == `PSCL_LATCH_WAIT)
		begin
			o_device_on <= 1'b1;
			buck1_v <= {4'h0, pin_pick[3:0]};
			if (both_high)
			begin
				reg_v_a <= {`PSCL_V_1P2, `PSCL_V_1P0};
				reg_v_b <= {pin_pick[7:4], `PSCL_V_1P0};
			end
			else
			begin
				reg_v_a <= {`PSCL_V_1P8, `PSCL_V_1P2};
				reg_v_b <= {pin_pick[7:4], `PSCL_V_2P8};
			end
		end
	end
	else if (wr_commit)
	begin
		// Any later write replaces the latched defaults.
		case (ptr)
			`PSCL_OFS_CTRL: ctrl <= shift;
			`PSCL_OFS_MODE: mode <= shift[`PSCL_MODE_BITS-1:0];
			`PSCL_OFS_BUCK1_V: buck1_v <= shift;
			`PSCL_OFS_REG_V_A: reg_v_a <= shift;
			`PSCL_OFS_REG_V_B: reg_v_b <= shift;
			default: ctrl <= ctrl;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////

wire [5:0] raw_en;
wire buck_hot;
wire reg_hot;

// Pin and bit combine by exclusive-OR per rail.
assign raw_en = en_pin ^ ctrl[`PSCL_CTRL_BUCK1_EN:`PSCL_CTRL_REG4_EN];
// Thermal trips are levels, so rails return on their own when cooled.
assign buck_hot = |buck_ot;
assign reg_hot = |reg_ot;

always @(posedge i_mclk or negedge i_rst_b)
begin
	if (!i_rst_b)
	begin
		o_sda_out <= 1'b0;
		o_host_reset_out <= 1'b0;
		o_host_reset_oe <= 1'b1;
		o_deep_power_down_output_out <= 1'b0;
		o_deep_power_down_output_oe <= 1'b1;
		o_buck1_enable <= 1'b0;
		o_buck2_enable <= 1'b0;
		o_regulator_enable <= 4'h0;
		o_conv_mode <= `PSCL_MODE_RESET;
		o_buck1_voltage_setting <= 8'h00;
		o_regulator_voltage_setting_a <= 8'h00;
		o_regulator_voltage_setting_b <= 8'h00;
		status <= 8'h3f;
	end
	else
	begin
		o_sda_out <= 1'b0;
		o_host_reset_out <= 1'b0;
		o_deep_power_down_output_out <= 1'b0;
		// A cleared bit pulls low; a set bit lets the pull-up win.
		o_host_reset_oe <= ~ctrl[`PSCL_CTRL_HOST_RESET];
		o_deep_power_down_output_oe <= ~ctrl[`PSCL_CTRL_DEEP_PD];
		o_buck1_enable <= o_device_on & raw_en[5] & ~buck_hot;
		o_buck2_enable <= o_device_on & raw_en[4] & ~buck_hot;
		o_regulator_enable <= {4{o_device_on & ~reg_hot}} & raw_en[3:0];
		o_conv_mode <= mode;
		o_buck1_voltage_setting <= buck1_v;
		o_regulator_voltage_setting_a <= reg_v_a;
		o_regulator_voltage_setting_b <= reg_v_b;
		// A rail out of range or not enabled reports not good.
		status <= {dis_above, dvm_act,
			~(rail_ok & {o_buck1_enable, o_buck2_enable, o_regulator_enable})};
	end
end

endmodule

/* dv/pscl_monitor.sv */
// Checker of port behaviour of the serial control logic top.
// Assumes it is bound into pscl_top and sees only its ports.
module pscl_monitor (
	input logic i_mclk,
	input logic i_rst_b,
	input logic i_scl,
	input logic i_regulator1_enable_pin,
	input logic [1:0] i_buck_overtemp,
	input logic [3:0] i_regulator_overtemp,
	input logic o_sda_out,
	input logic o_sda_oe,
	input logic o_host_reset_out,
	input logic o_host_reset_oe,
	input logic o_deep_power_down_output_out,
	input logic o_deep_power_down_output_oe,
	input logic o_device_on,
	input logic o_buck1_enable,
	input logic o_buck2_enable,
	input logic [3:0] o_regulator_enable
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	////////////////////////////////////////////////////////////////////////////////
	reset_low_a:
	assert property ($rose(i_rst_b) |-> o_host_reset_oe && o_deep_power_down_output_oe && !o_sda_oe)
		else $error("host outputs not low after release");
	od_drive_a:
	assert property (!o_sda_out && !o_host_reset_out && !o_deep_power_down_output_out)
		else $error("open-drain pin driven high");
	off_quiet_a:
	assert property (!o_device_on |-> !o_buck1_enable && !o_buck2_enable
		&& o_regulator_enable == 4'h0)
		else $error("rail enabled while off");
	on_release_a:
	assert property ($rose(i_rst_b) |-> ##[1:12] o_device_on)
		else $error("device not on after release");
	buck_trip_a:
	assert property ((|i_buck_overtemp) [*6] |-> !o_buck1_enable && !o_buck2_enable)
		else $error("buck left on in over-temperature");
	reg_trip_a:
	assert property ((|i_regulator_overtemp) [*6] |-> o_regulator_enable == 4'h0)
		else $error("regulator left on in over-temperature");
	// The window assumes software leaves the control register alone meanwhile.
	reg_xor_a:
	assert property ($rose(i_regulator1_enable_pin) && o_device_on && !(|i_regulator_overtemp)
		|-> ##5 o_regulator_enable[3] != $past(o_regulator_enable[3], 5))
		else $error("regulator1 enable did not follow its pin");
	ack_hold_a:
	assert property ($rose(o_sda_oe) |-> o_sda_oe [*4])
		else $error("data line drive too short");
	sda_stable_a:
	assert property (i_scl && $past(i_scl, 3) |=> $stable(o_sda_oe))
		else $error("data line moved while clock high");
endmodule

bind pscl_top pscl_monitor i_pscl_monitor (.*);

/* dv/pscl_host.sv */
// Behavioural bus master standing in for the host processor.
// Assumes a pull-up on the data line; the clock stands high between frames.
module pscl_host (
	output logic o_scl = 1'b1,
	output logic o_sda_oe = 1'b0,
	input wire logic i_sda
);
	timeunit 1ns;
	timeprecision 100ps;
	// Half period of the 200 ns bus clock.
	localparam int HALF = 100;
	////////////////////////////////////////////////////////////////////////////////
	task automatic bit_xfer(input logic b, output logic s);
		o_sda_oe = !b;
		#(HALF / 2);
		o_scl = 1'b1;
		#(HALF - 5);
		s = i_sda;
		#5;
		o_scl = 1'b0;
		#(HALF / 2);
	endtask
	// Open gives a start, otherwise a stop that leaves the bus idle.
	task automatic frame(input logic open);
		o_sda_oe = !open;
		#(HALF / 2);
		o_scl = 1'b1;
		#HALF;
		o_sda_oe = open;
		#HALF;
		o_scl = !open;
		#(HALF / 2);
	endtask
	task automatic byte_xfer(input logic [7:0] tx, input logic nack, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_xfer(tx[i], rx[i]);
		bit_xfer(nack, ack);
		ack = !ack;
	endtask
	task automatic xfer(input logic [6:0] dev, input logic rd, input logic [7:0] ofs,
		input logic [7:0] wd, output logic [7:0] val, output logic ok, output logic rel);
		logic [7:0] rx;
		logic a0, a1, a2, a3;
		rel = 1'b1;
		frame(1'b1);
		byte_xfer({dev, 1'b0}, 1'b1, rx, a0);
		byte_xfer(ofs, 1'b1, rx, a1);
		if (rd)
		begin
			frame(1'b1);
			byte_xfer({dev, 1'b1}, 1'b1, rx, a2);
			byte_xfer(8'hFF, 1'b1, val, a3);
			rel = i_sda;
		end
		else
			byte_xfer(wd, 1'b1, rx, a2);
		frame(1'b0);
		ok = a0 && a1 && a2;
	endtask
endmodule

/* dv/pscl_top_bench.sv */
// Self-checking bench of the serial control logic with a modelled host.
// Assumes the host model owns the bus clock; the data line has a pull-up.
`include "pscl_map.vh"

module pscl_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [1:0] b; logic [1:0] a; logic [7:0] sa; logic [7:0] sb;
		logic [7:0] v1;} pscl_row_t;
	// Pin levels are 0 low, 1 high, 2 floating.
	pscl_row_t rows [9] = '{'{0, 0, 8'h31, 8'h26, 8'h05}, '{0, 2, 8'h31, 8'h66, 8'h03},
		'{0, 1, 8'h31, 8'h26, 8'h03}, '{2, 0, 8'h31, 8'h66, 8'h05}, '{2, 2, 8'h31, 8'h36, 8'h05},
		'{2, 1, 8'h31, 8'h66, 8'h01}, '{1, 0, 8'h31, 8'h06, 8'h04}, '{1, 2, 8'h31, 8'h76, 8'h05},
		'{1, 1, 8'h10, 8'h00, 8'h01}};
	logic i_mclk = 1'b0, i_rst_b = 1'b0, i_buck1_enable_pin = 1'b0, i_buck2_enable_pin = 1'b0;
	logic i_regulator1_enable_pin = 1'b0, i_regulator2_enable_pin = 1'b0;
	logic i_regulator3_enable_pin = 1'b0, i_regulator4_enable_pin = 1'b0;
	logic i_default_select_pin_a = 1'b0, i_default_select_pin_a_float = 1'b0;
	logic i_default_select_pin_b = 1'b0, i_default_select_pin_b_float = 1'b0;
	logic [1:0] i_buck_overtemp = 2'h0;
	logic [3:0] i_regulator_overtemp = 4'h0;
	logic [5:0] i_rail_in_range = 6'h00;
	logic i_discharge_above = 1'b0, i_voltage_transition_active = 1'b0, ok, rel;
	logic [7:0] rd;
	wire logic i_scl, host_oe, o_sda_out, o_sda_oe, o_host_reset_out, o_host_reset_oe, o_device_on;
	wire logic o_deep_power_down_output_out, o_deep_power_down_output_oe;
	wire logic o_buck1_enable, o_buck2_enable;
	wire logic [3:0] o_regulator_enable, o_conv_mode;
	wire logic [7:0] o_buck1_voltage_setting, o_regulator_voltage_setting_a;
	wire logic [7:0] o_regulator_voltage_setting_b;
	// Open drain: the line is low while either side pulls it.
	wire logic i_sda = !(o_sda_oe || host_oe);
	wire logic [7:0] od_vec = {4'h0, o_host_reset_oe, o_deep_power_down_output_oe, o_device_on, o_sda_oe};
	wire logic [7:0] en_vec = {2'b00, o_buck1_enable, o_buck2_enable, o_regulator_enable};
	int fails = 0, samples_checked = 0;
	pscl_top i_pscl_top (.*);
	pscl_host i_pscl_host (.o_scl(i_scl), .o_sda_oe(host_oe), .i_sda(i_sda));
	always #12.5 i_mclk = !i_mclk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// Inputs always move 2 ns after a rising edge so no race with the design.
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
		#2;
	endtask
	task automatic do_reset();
		cyc(1);
		i_rst_b = 1'b0;
		cyc(8);
		i_rst_b = 1'b1;
		cyc(16);
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] val);
		i_pscl_host.xfer(dev, 1'b0, ofs, val, rd, ok, rel);
		cyc(6);
	endtask
	task automatic rdr(input logic [7:0] ofs);
		i_pscl_host.xfer(`PSCL_TARGET_ADDR, 1'b1, ofs, 8'h00, rd, ok, rel);
		cyc(1);
	endtask
	task automatic pins(input logic [5:0] p);
		{i_buck1_enable_pin, i_buck2_enable_pin, i_regulator1_enable_pin, i_regulator2_enable_pin,
			i_regulator3_enable_pin, i_regulator4_enable_pin} = p;
		cyc(8);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#400us;
		fails++;
		end_of_test();
	end
	initial
	begin
		foreach (rows[n])
		begin
			i_default_select_pin_a = rows[n].a == 2'd1;
			i_default_select_pin_a_float = rows[n].a == 2'd2;
			i_default_select_pin_b = rows[n].b == 2'd1;
			i_default_select_pin_b_float = rows[n].b == 2'd2;
			do_reset();
			check("setting_a", rows[n].sa, o_regulator_voltage_setting_a);
			check("setting_b", rows[n].sb, o_regulator_voltage_setting_b);
			check("buck1_setting", rows[n].v1, o_buck1_voltage_setting);
		end
		$display("test defaults done");
		check("outputs", 8'h0E, od_vec);
		check("enables", 8'h00, en_vec);
		check("conv_mode", {4'h0, `PSCL_MODE_RESET}, {4'h0, o_conv_mode});
		wr(`PSCL_TARGET_ADDR, `PSCL_OFS_CTRL, 8'hC0);
		check("ack", 8'h01, {7'h00, ok});
		check("outputs", 8'h02, od_vec);
		rdr(`PSCL_OFS_CTRL);
		check("ctrl", 8'hC0, rd);
		check("release", 8'h01, {7'h00, rel});
		$display("test host outputs done");
		wr(`PSCL_TARGET_ADDR, `PSCL_OFS_CTRL, 8'hE5);
		pins(6'b110011);
		check("enables", 8'h16, en_vec);
		pins(6'b111011);
		check("enables", 8'h1E, en_vec);
		i_rail_in_range = 6'b110111;
		i_discharge_above = 1'b1;
		cyc(4);
		rdr(`PSCL_OFS_STATUS);
		check("status", 8'hA9, rd);
		wr(`PSCL_TARGET_ADDR, `PSCL_OFS_STATUS, 8'h00);
		rdr(`PSCL_OFS_STATUS);
		check("status", 8'hA9, rd);
		$display("test enables done");
		i_buck_overtemp = 2'b10;
		cyc(8);
		check("enables", 8'h0E, en_vec);
		i_buck_overtemp = 2'b00;
		cyc(8);
		check("enables", 8'h1E, en_vec);
		i_regulator_overtemp = 4'b0100;
		cyc(8);
		check("enables", 8'h10, en_vec);
		i_regulator_overtemp = 4'b0000;
		cyc(8);
		$display("test thermal done");
		rdr(8'h20);
		check("unmapped", `PSCL_UNMAPPED_READ, rd);
		wr(`PSCL_TARGET_ADDR, `PSCL_OFS_REG_V_A, 8'h77);
		check("setting_a", 8'h77, o_regulator_voltage_setting_a);
		wr(`PSCL_TARGET_ADDR, `PSCL_OFS_BUCK1_V, 8'h07);
		check("buck1_setting", 8'h07, o_buck1_voltage_setting);
		wr(`PSCL_TARGET_ADDR, `PSCL_OFS_REG_V_B, 8'h45);
		check("setting_b", 8'h45, o_regulator_voltage_setting_b);
		wr(`PSCL_TARGET_ADDR, `PSCL_OFS_MODE, 8'hFA);
		check("conv_mode", 8'h0A, {4'h0, o_conv_mode});
		rdr(`PSCL_OFS_MODE);
		check("mode", 8'h0A, rd);
		wr(7'h49, `PSCL_OFS_CTRL, 8'h00);
		check("ack", 8'h00, {7'h00, ok});
		check("outputs", 8'h02, od_vec);
		do_reset();
		check("outputs", 8'h0E, od_vec);
		check("setting_a", 8'h10, o_regulator_voltage_setting_a);
		check("enables", 8'h3B, en_vec);
		check("setting_b", 8'h00, o_regulator_voltage_setting_b);
		check("buck1_setting", 8'h01, o_buck1_voltage_setting);
		check("conv_mode", {4'h0, `PSCL_MODE_RESET}, {4'h0, o_conv_mode});
		$display("test access and reset done");
		end_of_test();
	end
endmodule
